// ---- design/dcm_pkg.sv ----
package dcm_pkg;
  localparam int ClkMhz = 200;
  localparam int WatchdogTimeoutMs = 310;
  localparam int WatchdogTimeoutCyc = WatchdogTimeoutMs * ClkMhz * 1000;
  localparam int InputIdleMs = 250;
  localparam int InputIdleCyc = InputIdleMs * ClkMhz * 1000;
  localparam int WakeSettleUs = 50;
  localparam int WakeSettleCyc = WakeSettleUs * ClkMhz;
  localparam int PwmMaxHz = 1000;
  localparam int PwmMinPeriodCyc = ClkMhz * 1000000 / PwmMaxHz;

  localparam logic [7:0] AddrCtrl0 = 8'h00;
  localparam logic [7:0] AddrCtrl1 = 8'h04;
  localparam logic [7:0] AddrGlobalConfig = 8'h08;
  localparam logic [7:0] AddrWatchdogKick = 8'h0c;
  localparam logic [7:0] AddrStatus = 8'h10;

  localparam int CtrlDutyLsb = 0;
  localparam int CtrlOnBit = 8;
  localparam int CtrlPwmEnBit = 9;
  localparam int CtrlIntClkBit = 10;
  localparam int CtrlDirDisBit = 11;
  localparam int CtrlSlewLsb = 12;
  localparam int CtrlDelayLsb = 14;
  localparam int CtrlDivLsb = 16;
  localparam logic [31:0] CtrlReset = 32'h0000_0000;

  localparam int GcfgVddFailEnBit = 0;
  localparam int GcfgSupplyHighQualBit = 1;
  localparam int GcfgWatchdogDisBit = 4;
  localparam int GcfgPowerOnBit = 5;
  localparam int GcfgParallelBit = 6;
  localparam logic [31:0] GcfgReset = 32'h0000_0000;
  localparam logic [31:0] GcfgKeepMask = 32'h0000_0060;

  localparam int StatModeLsb = 0;
  localparam int StatNormalBit = 2;
  localparam int StatReadyBit = 3;
  localparam int StatActiveLsb = 4;
  localparam int StatHsonLsb = 6;

  typedef enum logic [1:0] {
    ModeSleep = 2'b00,
    ModeNormal = 2'b01,
    ModeFailsafe = 2'b11,
    ModeFault = 2'b10
  } dcm_mode_t;
endpackage

// ---- design/dcm_mode_controller.sv ----
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - mode is Sleep, Normal, Fail-safe or Fault from wake, fail-safe and fault terms
// - wake is release line high or either channel's input-activity signal
// - fail-safe on enabled supply failure or watchdog timeout when not disabled
// - fault ORs channel faults, low supply, and qualified supply-high fault
// - Sleep keeps both channels off
// - Fault forces the channels off
// - Fail-safe drives each channel from its direct input only
// - wake resets registers, enters Normal; full function about 50 us later
// - rising edge on release line or a direct input enters Normal
// - input idle longer than 250 ms drops that channel's activity signal
// - both activity signals low and release line low gives Sleep
// - drive is input gated by disable, or on AND duty when PWM on, or on
// - duty term comes from the eight low bits of the pulse-width register
// - direct input mode uses default delay and slew code 00
// - internal clock mode: per-channel frequency, slew, duty, delay programmable
// - external clock mode takes frequency from the clock pin
// - release line low or Fail-safe: channels driven from direct inputs only
// - global config bit 4 disables watchdog; timeout then ignored
// - normal state flag reads 1 while in Normal
// - PWM supports up to 1.0 kHz from internal or external clock
// - Fail-safe entry drives indicator low; entry from Normal also clears faults, resets registers except global config bits 5 and 6
module dcm_mode_controller #(
  parameter int WatchdogCyc = dcm_pkg::WatchdogTimeoutCyc,
  parameter int InputIdleCyc = dcm_pkg::InputIdleCyc,
  parameter int WakeSettleCyc = dcm_pkg::WakeSettleCyc
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_release_n_line,
  input wire logic [1:0] directIn,
  input wire logic extPwmClk,
  input wire logic vddFail,
  input wire logic [1:0] excess_current_fault,
  input wire logic [1:0] thermal_fault,
  input wire logic [1:0] severe_short_fault,
  input wire logic low_supply_fault,
  input wire logic supply_high_fault,
  output logic [1:0] hsOn,
  output logic [1:0] slewCode,
  output logic [3:0] turnOnDelay,
  output logic failsafe_indicator_n,
  output logic fault_indicator_n,
  output logic faultDelatch,
  output logic [1:0] opMode
);
  typedef dcm_pkg::dcm_mode_t dcm_mode_t;
  typedef struct packed {
    logic [1:0] relSync1;
    logic [1:0] relSync2;
    logic [1:0] relPrev;
    logic [1:0] in1;
    logic [1:0] in2;
    logic [1:0] inPrev;
    logic [1:0] ext1;
    logic [1:0] ext2;
    logic extPrev;
    logic [1:0] active;
    logic [1:0][31:0] idleCnt;
    logic [31:0] wdCnt;
    logic wdRun;
    logic wdExpired;
    logic wdLastBit;
    logic wdSeenOne;
    logic [31:0] settleCnt;
    logic ready;
    dcm_mode_t mode;
    logic [1:0][31:0] ctrl;
    logic [31:0] gcfg;
    logic [1:0][7:0] pwmPhase;
    logic [1:0][15:0] divCnt;
    logic [1:0] hs;
    logic delatch;
    logic [31:0] rdata;
  } dcm_state_t;

  dcm_state_t st_q;
  dcm_state_t st_d;

  function automatic dcm_mode_t pickMode(input logic wake, input logic fs, input logic flt);
    if (!wake) begin
      pickMode = dcm_pkg::ModeSleep;
    end else if (flt) begin
      pickMode = dcm_pkg::ModeFault;
    end else if (fs) begin
      pickMode = dcm_pkg::ModeFailsafe;
    end else begin
      pickMode = dcm_pkg::ModeNormal;
    end
  endfunction

  logic wakeTerm;
  logic failTerm;
  logic faultTerm;
  logic relHigh;
  logic relRise;
  logic [1:0] inRise;
  logic extRise;
  logic apbWrite;
  logic apbRead;
  logic wakeEvent;

  always_comb begin
    relHigh = st_q.relSync2[1];
    relRise = relHigh && !st_q.relPrev[1];
    inRise = st_q.in2 & ~st_q.inPrev;
    extRise = st_q.ext2[1] && !st_q.extPrev;
    wakeTerm = relHigh || (|st_q.active);
    failTerm = (vddFail && st_q.gcfg[dcm_pkg::GcfgVddFailEnBit])
      || (st_q.wdExpired && !st_q.gcfg[dcm_pkg::GcfgWatchdogDisBit]);
    faultTerm = (|excess_current_fault) || (|thermal_fault) || (|severe_short_fault)
      || low_supply_fault
      || (supply_high_fault && st_q.gcfg[dcm_pkg::GcfgSupplyHighQualBit]);
    apbWrite = psel && penable && pwrite;
    apbRead = psel && !penable && !pwrite;
    wakeEvent = (st_q.mode == dcm_pkg::ModeSleep) && (relRise || (|inRise));
  end

  always_comb begin
    logic regsOpen;
    logic [1:0] spiOn;
    logic [1:0] nextHs;
    dcm_mode_t nextMode;
    regsOpen = 1'b0;
    spiOn = 2'b00;
    nextHs = 2'b00;
    nextMode = dcm_pkg::ModeSleep;
    st_d = st_q;
    st_d.relSync1 = {1'b0, wake_release_n_line};
    st_d.relSync2 = {st_q.relSync1[0], 1'b0};
    st_d.relPrev = st_q.relSync2;
    st_d.in1 = directIn;
    st_d.in2 = st_q.in1;
    st_d.inPrev = st_q.in2;
    st_d.ext1 = {1'b0, extPwmClk};
    st_d.ext2 = {st_q.ext1[0], 1'b0};
    st_d.extPrev = st_q.ext2[1];

    // activity counts from the last high level, so a held input never times out
    for (int c = 0; c < 2; c++) begin
      if (st_q.in2[c]) begin
        st_d.idleCnt[c] = '0;
        st_d.active[c] = 1'b1;
      end else if (st_q.idleCnt[c] >= 32'(InputIdleCyc)) begin
        st_d.active[c] = 1'b0;
      end else begin
        st_d.idleCnt[c] = st_q.idleCnt[c] + 32'd1;
      end
    end

    nextMode = pickMode(wakeTerm, failTerm, faultTerm);
    if (wakeEvent) begin
      nextMode = dcm_pkg::ModeNormal;
    end
    st_d.mode = nextMode;

    st_d.delatch = 1'b0;
    if (wakeEvent) begin
      st_d.ctrl = {dcm_pkg::CtrlReset, dcm_pkg::CtrlReset};
      st_d.gcfg = dcm_pkg::GcfgReset;
      st_d.settleCnt = '0;
      st_d.ready = 1'b0;
      st_d.wdCnt = '0;
      st_d.wdExpired = 1'b0;
      st_d.wdRun = relRise;
      st_d.wdSeenOne = 1'b0;
    end else if (st_q.mode != dcm_pkg::ModeSleep && !st_q.ready) begin
      if (st_q.settleCnt >= 32'(WakeSettleCyc - 1)) begin
        st_d.ready = 1'b1;
      end else begin
        st_d.settleCnt = st_q.settleCnt + 32'd1;
      end
    end
    if (nextMode == dcm_pkg::ModeFailsafe && st_q.mode == dcm_pkg::ModeNormal) begin
      st_d.ctrl = {dcm_pkg::CtrlReset, dcm_pkg::CtrlReset};
      st_d.gcfg = (st_q.gcfg & dcm_pkg::GcfgKeepMask) | dcm_pkg::GcfgReset;
      st_d.delatch = 1'b1;
      st_d.wdSeenOne = 1'b0;
    end
    if (nextMode == dcm_pkg::ModeSleep) begin
      st_d.ctrl = {dcm_pkg::CtrlReset, dcm_pkg::CtrlReset};
      st_d.gcfg = dcm_pkg::GcfgReset;
      st_d.wdRun = 1'b0;
      st_d.wdExpired = 1'b0;
      st_d.ready = 1'b0;
    end
    // a release edge after an input-only wake still arms the watchdog
    if (relRise && !wakeEvent) begin
      st_d.wdRun = 1'b1;
      st_d.wdCnt = '0;
    end

    // watchdog: only writes to the kick address count; before expiry only a changed bit restarts
    if (st_q.wdRun && !wakeEvent) begin
      if (apbWrite && paddr == dcm_pkg::AddrWatchdogKick) begin
        if (st_q.wdExpired) begin
          if (st_q.wdSeenOne) begin
            st_d.wdExpired = 1'b0;
            st_d.wdCnt = '0;
          end else if (pwdata[0]) begin
            st_d.wdSeenOne = 1'b1;
            st_d.wdCnt = '0;
          end
        end else if (pwdata[0] != st_q.wdLastBit) begin
          st_d.wdCnt = '0;
        end
        st_d.wdLastBit = pwdata[0];
      end else if (st_q.wdCnt >= 32'(WatchdogCyc - 1)) begin
        st_d.wdExpired = 1'b1;
        st_d.wdSeenOne = 1'b0;
        st_d.wdCnt = '0;
      end else begin
        st_d.wdCnt = st_q.wdCnt + 32'd1;
      end
    end

    regsOpen = (st_q.mode == dcm_pkg::ModeNormal) && relHigh;
    if (apbWrite && regsOpen && !wakeEvent) begin
      unique case (paddr)
        dcm_pkg::AddrCtrl0: st_d.ctrl[0] = pwdata;
        dcm_pkg::AddrCtrl1: st_d.ctrl[1] = pwdata;
        dcm_pkg::AddrGlobalConfig: st_d.gcfg = pwdata;
        default: ;
      endcase
    end

    for (int c = 0; c < 2; c++) begin
      logic tick;
      logic [15:0] div;
      tick = 1'b0;
      div = st_q.ctrl[c][dcm_pkg::CtrlDivLsb +: 16];
      // one pwm period is 256 ticks; divider sets the internal frequency
      if (st_q.ctrl[c][dcm_pkg::CtrlIntClkBit]) begin
        if (st_q.divCnt[c] >= div) begin
          st_d.divCnt[c] = '0;
          tick = 1'b1;
        end else begin
          st_d.divCnt[c] = st_q.divCnt[c] + 16'd1;
        end
      end else begin
        st_d.divCnt[c] = '0;
        tick = extRise;
      end
      if (tick) begin
        st_d.pwmPhase[c] = st_q.pwmPhase[c] + 8'd1;
      end
      if (st_q.ctrl[c][dcm_pkg::CtrlPwmEnBit]) begin
        spiOn[c] = st_q.ctrl[c][dcm_pkg::CtrlOnBit]
          && (st_q.pwmPhase[c] < st_q.ctrl[c][dcm_pkg::CtrlDutyLsb +: 8]);
      end else begin
        spiOn[c] = st_q.ctrl[c][dcm_pkg::CtrlOnBit];
      end
      unique case (st_q.mode)
        dcm_pkg::ModeNormal: begin
          if (!relHigh) begin
            nextHs[c] = st_q.in2[c];
          end else begin
            nextHs[c] = (st_q.in2[c] && !st_q.ctrl[c][dcm_pkg::CtrlDirDisBit])
              || spiOn[c];
          end
        end
        dcm_pkg::ModeFailsafe: nextHs[c] = st_q.in2[c];
        dcm_pkg::ModeFault: nextHs[c] = 1'b0;
        dcm_pkg::ModeSleep: nextHs[c] = 1'b0;
      endcase
    end
    st_d.hs = nextHs;

    st_d.rdata = '0;
    if (apbRead) begin
      unique case (paddr)
        dcm_pkg::AddrCtrl0: st_d.rdata = st_q.ctrl[0];
        dcm_pkg::AddrCtrl1: st_d.rdata = st_q.ctrl[1];
        dcm_pkg::AddrGlobalConfig: st_d.rdata = st_q.gcfg;
        dcm_pkg::AddrStatus: begin
          st_d.rdata[dcm_pkg::StatModeLsb +: 2] = st_q.mode;
          st_d.rdata[dcm_pkg::StatNormalBit] = (st_q.mode == dcm_pkg::ModeNormal);
          st_d.rdata[dcm_pkg::StatReadyBit] = st_q.ready;
          st_d.rdata[dcm_pkg::StatActiveLsb +: 2] = st_q.active;
          st_d.rdata[dcm_pkg::StatHsonLsb +: 2] = st_q.hs;
        end
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  logic addrOk;
  always_comb begin
    addrOk = (paddr == dcm_pkg::AddrCtrl0) || (paddr == dcm_pkg::AddrCtrl1)
      || (paddr == dcm_pkg::AddrGlobalConfig) || (paddr == dcm_pkg::AddrWatchdogKick)
      || (paddr == dcm_pkg::AddrStatus);
    pready = psel && penable;
    pslverr = psel && penable && !addrOk;
    prdata = st_q.rdata;
    hsOn = st_q.hs;
    opMode = st_q.mode;
    faultDelatch = st_q.delatch;
    failsafe_indicator_n = (st_q.mode != dcm_pkg::ModeFailsafe);
    fault_indicator_n = (st_q.mode != dcm_pkg::ModeFault);
    // direct-input drive uses the default timing code
    for (int c = 0; c < 2; c++) begin
      if (st_q.mode == dcm_pkg::ModeNormal && relHigh) begin
        slewCode[c] = st_q.ctrl[c][dcm_pkg::CtrlSlewLsb];
        turnOnDelay[2*c +: 2] = st_q.ctrl[c][dcm_pkg::CtrlDelayLsb +: 2];
      end else begin
        slewCode[c] = 1'b0;
        turnOnDelay[2*c +: 2] = 2'b00;
      end
    end
  end
endmodule

// ---- testbench/dcm_mode_checker_properties.sv ----
`timescale 1ns/1ps
module dcm_mode_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wake_release_n_line,
  input wire logic [1:0] directIn,
  input wire logic [1:0] hsOn,
  input wire logic failsafe_indicator_n,
  input wire logic fault_indicator_n,
  input wire logic faultDelatch,
  input wire logic [1:0] opMode
);
  localparam logic [1:0] MSlp = dcm_pkg::ModeSleep;
  localparam logic [1:0] MNrm = dcm_pkg::ModeNormal;
  localparam logic [1:0] MFs = dcm_pkg::ModeFailsafe;
  localparam logic [1:0] MFlt = dcm_pkg::ModeFault;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_sleep_off; opMode == MSlp ##1 opMode == MSlp |-> hsOn == 2'b00; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("drive in sleep");
  property p_fault_off; opMode == MFlt ##1 opMode == MFlt |-> hsOn == 2'b00; endproperty
  a_fault_off: assert property (p_fault_off) else $error("drive in fault");
  // five stable cycles cover input sync plus the drive register
  property p_fs_direct; (opMode == MFs && $stable(directIn))[*5] |-> hsOn == directIn; endproperty
  a_fs_direct: assert property (p_fs_direct) else $error("fail-safe drive");
  property p_fs_ind; $stable(opMode == MFs) |-> failsafe_indicator_n == (opMode != MFs); endproperty
  a_fs_ind: assert property (p_fs_ind) else $error("fail-safe flag");
  property p_flt_ind; $stable(opMode == MFlt) |-> fault_indicator_n == (opMode != MFlt); endproperty
  a_flt_ind: assert property (p_flt_ind) else $error("fault flag");
  property p_delatch; faultDelatch |-> $past(opMode) == MNrm ##1 !faultDelatch; endproperty
  a_delatch: assert property (p_delatch) else $error("delatch pulse");
  property p_sleep_in; opMode == MSlp && $past(opMode) != MSlp |-> !$past(wake_release_n_line, 3);
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("sleep with release high");
  property p_wake; $rose(wake_release_n_line) && opMode == MSlp |-> ##[1:8] opMode == MNrm;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  c_fs: cover property (opMode == MFs);
  c_flt: cover property (opMode == MFlt);
  c_wake: cover property (opMode == MSlp ##1 opMode == MNrm);
endmodule
bind dcm_mode_controller dcm_mode_checker dcm_mode_checker_i (.core_clk(core_clk),
  .sys_rst(sys_rst), .wake_release_n_line(wake_release_n_line), .directIn(directIn),
  .hsOn(hsOn), .failsafe_indicator_n(failsafe_indicator_n),
  .fault_indicator_n(fault_indicator_n), .faultDelatch(faultDelatch), .opMode(opMode));

// ---- testbench/dcm_host_model.sv ----
`timescale 1ns/1ps
module dcm_host_model (
  input wire logic core_clk,
  input wire logic relReq,
  input wire logic [1:0] inReq,
  output logic wake_release_n_line = 1'b0,
  output logic [1:0] directIn = 2'b00
);
  // pins only move after an edge, as a clocked controller port would
  always @(posedge core_clk) begin
    wake_release_n_line <= relReq;
    directIn <= inReq;
  end
endmodule

// ---- testbench/dual_channel_mode_controller_bench.sv ----
`timescale 1ns/1ps
module dual_channel_mode_controller_bench;
  localparam logic [1:0] MSlp = dcm_pkg::ModeSleep;
  localparam logic [1:0] MNrm = dcm_pkg::ModeNormal;
  localparam logic [1:0] MFs = dcm_pkg::ModeFailsafe;
  localparam logic [1:0] MFlt = dcm_pkg::ModeFault;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, relReq = 0, se;
  logic vdd = 0, extRun = 0, extClk = 0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] flt = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rel, fsN, flN, dl;
  logic [1:0] inReq = 2'b00, dIn, hsOn, slew, opMode;
  logic [3:0] dly;
  int errors = 0, n_compared = 0;
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // external pwm clock: one rising edge every two core cycles while running
  always @(posedge core_clk) extClk <= extRun && !extClk;
  dcm_host_model dcm_host_model_i (.core_clk(core_clk), .relReq(relReq), .inReq(inReq),
    .wake_release_n_line(rel), .directIn(dIn));
  dcm_mode_controller #(.WatchdogCyc(400), .InputIdleCyc(100), .WakeSettleCyc(20))
    dcm_mode_controller_i (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_release_n_line(rel), .directIn(dIn),
    .extPwmClk(extClk), .vddFail(vdd), .excess_current_fault(flt[1:0]),
    .thermal_fault(flt[3:2]), .severe_short_fault(flt[5:4]), .low_supply_fault(flt[6]),
    .supply_high_fault(flt[7]), .hsOn(hsOn), .slewCode(slew), .turnOnDelay(dly),
    .failsafe_indicator_n(fsN), .fault_indicator_n(flN), .faultDelatch(dl), .opMode(opMode));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      chk(pready, 1'b1);
      give_verdict();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_mode(input logic [1:0] m, input int lim);
    for (int i = 0; i < lim && opMode !== m; i++) @(posedge core_clk);
    chk(opMode, m);
    if (opMode !== m) give_verdict();
  endtask
  // period is 256 ticks: a 512-cycle window holds two periods at divider 0, one on the two-cycle external clock
  task automatic duty_cnt(input int exp);
    int c;
    c = 0;
    repeat (512) begin
      @(posedge core_clk);
      c += (hsOn[1] === 1'b1);
    end
    chk(c, exp);
  endtask
  initial begin
    cyc(8);
    sys_rst <= 1'b0;
    cyc(2);
    chk({opMode, hsOn, fsN, flN}, 6'b000011);
    $display("reset test done");
    relReq <= 1'b1;
    wait_mode(MNrm, 20);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, dcm_pkg::AddrWatchdogKick, {31'h0, ~i[0]});
      cyc(100);
    end
    chk(opMode, MNrm);
    apb(1'b1, dcm_pkg::AddrGlobalConfig, 32'h1);
    vdd <= 1'b1;
    wait_mode(MFs, 10);
    vdd <= 1'b0;
    wait_mode(MNrm, 10);
    apb(1'b1, dcm_pkg::AddrGlobalConfig, 32'h10);
    apb(1'b0, dcm_pkg::AddrCtrl0, 32'h0);
    chk(rd, dcm_pkg::CtrlReset);
    apb(1'b0, dcm_pkg::AddrStatus, 32'h0);
    chk(rd[2:0], 3'b101);
    cyc(25);
    apb(1'b0, dcm_pkg::AddrStatus, 32'h0);
    chk(rd[3], 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk(se, 1'b1);
    chk(rd, 32'h0);
    $display("wake test done");
    apb(1'b1, dcm_pkg::AddrCtrl0, 32'h100);
    cyc(4);
    chk(hsOn[0], 1'b1);
    apb(1'b1, dcm_pkg::AddrCtrl1, 32'h700);
    cyc(4);
    duty_cnt(0);
    apb(1'b1, dcm_pkg::AddrCtrl1, 32'h780);
    cyc(4);
    duty_cnt(256);
    extRun <= 1'b1;
    apb(1'b1, dcm_pkg::AddrCtrl1, 32'h380);
    cyc(4);
    duty_cnt(256);
    extRun <= 1'b0;
    apb(1'b1, dcm_pkg::AddrCtrl1, 32'h0);
    apb(1'b1, dcm_pkg::AddrCtrl0, 32'h0);
    inReq <= 2'b01;
    cyc(6);
    chk(hsOn, 2'b01);
    chk({slew, dly}, 6'h00);
    apb(1'b1, dcm_pkg::AddrCtrl0, 32'hd800);
    cyc(4);
    chk(hsOn, 2'b00);
    chk({slew, dly}, 6'h13);
    $display("drive test done");
    chk(opMode, MNrm);
    apb(1'b1, dcm_pkg::AddrGlobalConfig, 32'h0);
    wait_mode(MFs, 450);
    cyc(6);
    chk({fsN, hsOn}, 3'b001);
    apb(1'b1, dcm_pkg::AddrCtrl1, 32'h100);
    cyc(4);
    chk(hsOn, 2'b01);
    $display("fail-safe test done");
    for (int i = 0; i < 8; i++) begin
      flt <= 8'h01 << i;
      cyc(8);
      chk(opMode, (i == 7) ? MFs : MFlt);
      chk({flN, hsOn}, (i == 7) ? 3'b101 : 3'b000);
      flt <= 8'h00;
      cyc(8);
    end
    $display("fault test done");
    apb(1'b1, dcm_pkg::AddrWatchdogKick, 32'h1);
    apb(1'b1, dcm_pkg::AddrWatchdogKick, 32'h0);
    wait_mode(MNrm, 10);
    $display("fail-safe exit test done");
    relReq <= 1'b0;
    inReq <= 2'b00;
    cyc(50);
    chk(opMode, MNrm);
    wait_mode(MSlp, 120);
    cyc(2);
    chk(hsOn, 2'b00);
    inReq <= 2'b10;
    wait_mode(MNrm, 20);
    cyc(4);
    chk(hsOn, 2'b10);
    $display("sleep test done");
    give_verdict();
  end
endmodule
